// [core/rf_flag_pkg.sv]
// Constants, types and helpers shared by the request flag filter.
// Assumes 32-bit AHB-Lite register access and byte-wide receive data.
package rf_flag_pkg;

  // ----------------------------------------------------------------
  // Request flag positions (bit 1 of the frame is index 0)
  // ----------------------------------------------------------------
  localparam int unsigned FLAG_DUAL_TONE = 0;
  localparam int unsigned FLAG_SPEED = 1;
  localparam int unsigned FLAG_CENSUS = 2;
  localparam int unsigned FLAG_GROWTH = 3;
  localparam int unsigned FLAG_CHOSEN = 4;
  localparam int unsigned FLAG_UID_MATCH = 5;
  localparam int unsigned FLAG_OPTION = 6;
  localparam int unsigned FLAG_APP_FAMILY = 4;
  localparam int unsigned FLAG_SLOT_COUNT = 5;

  // ----------------------------------------------------------------
  // Response flags and error codes
  // ----------------------------------------------------------------
  localparam int unsigned RESP_FAULT = 0;
  localparam logic [7:0] ERR_CODE_OPTION = 8'h03;
  localparam logic [7:0] ERR_CODE_GENERIC = 8'h0f;
  localparam logic [7:0] ERR_CODE_NO_BLOCK = 8'h10;
  localparam logic [7:0] ERR_CODE_RELOCK = 8'h11;
  localparam logic [7:0] ERR_CODE_LOCKED = 8'h12;
  localparam logic [7:0] ERR_CODE_PROGRAM = 8'h13;
  localparam logic [7:0] ERR_CODE_LOCK_FAIL = 8'h14;
  localparam logic [7:0] ERR_CODE_READ_PROT = 8'h15;

  typedef enum logic [2:0] {
    ERR_OPTION, ERR_GENERIC, ERR_NO_BLOCK, ERR_RELOCK,
    ERR_LOCKED, ERR_PROGRAM, ERR_LOCK_FAIL, ERR_READ_PROT
  } err_kind_t;

  typedef enum logic [1:0] {
    TAG_READY, TAG_QUIET, TAG_SELECTED, TAG_SPARE
  } tag_state_t;

  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATE = 8'h04;
  localparam logic [7:0] REG_UID_LO = 8'h08;
  localparam logic [7:0] REG_UID_HI = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RESULT = 8'h14;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] UID_RESET = 32'h0000_0000;
  localparam int unsigned UID_BYTES = 8;

  // Map an executor error kind onto its reply code
  function automatic logic [7:0] err_code_of(input err_kind_t kind);
    case (kind)
      ERR_OPTION: err_code_of = ERR_CODE_OPTION;
      ERR_NO_BLOCK: err_code_of = ERR_CODE_NO_BLOCK;
      ERR_RELOCK: err_code_of = ERR_CODE_RELOCK;
      ERR_LOCKED: err_code_of = ERR_CODE_LOCKED;
      ERR_PROGRAM: err_code_of = ERR_CODE_PROGRAM;
      ERR_LOCK_FAIL: err_code_of = ERR_CODE_LOCK_FAIL;
      ERR_READ_PROT: err_code_of = ERR_CODE_READ_PROT;
      default: err_code_of = ERR_CODE_GENERIC;
    endcase
  endfunction

endpackage

// [core/reg_bus_if.sv]
// Internal register strobe bus between the AHB port and the filter.
// Assumes one clock; the read data is combinational from the registers.
`timescale 1ns/1ns
interface reg_bus_if;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport port (output wr, output rd, output addr, output wdata,
    input rdata);
  modport regs (input wr, input rd, input addr, input wdata,
    output rdata);
endinterface

// [core/ahb_reg_port.sv]
// AHB-Lite slave front end turning transfers into register strobes.
// Assumes single word transfers; reads take one wait state.
`timescale 1ns/1ns
module ahb_reg_port (
  // Clock, reset and enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Register strobes
  reg_bus_if.port bus
);
  logic dp_wr;
  logic dp_rd;
  logic rd_done;
  logic [7:0] dp_addr;
  wire take = ce & hsel & htrans[1] & hready;
  wire word = (hsize == 3'h2);

  // Reads wait one cycle so that hrdata comes from a flip-flop
  assign hreadyout = ce & ~(dp_rd & ~rd_done);
  assign hresp = 1'b0;
  assign bus.wr = ce & dp_wr;
  assign bus.rd = ce & dp_rd & ~rd_done;
  assign bus.addr = dp_addr;
  assign bus.wdata = hwdata;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr <= 1'b0;
      dp_rd <= 1'b0;
      rd_done <= 1'b0;
      dp_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else if (ce) begin
      if (hready) begin
        dp_wr <= take & hwrite & word;
        dp_rd <= take & ~hwrite;
        dp_addr <= haddr[7:0];
        rd_done <= 1'b0;
      end else if (bus.rd) begin
        hrdata <= bus.rdata;
        rd_done <= 1'b1;
      end
    end
  end
endmodule

// [core/uid_byte_compare.sv]
// Byte-serial compare of a received identifier against the tag's own.
// Assumes bytes arrive least significant first, one per valid pulse.
`timescale 1ns/1ns
module uid_byte_compare #(
  parameter int unsigned NBYTES = rf_flag_pkg::UID_BYTES
) (
  // Clock, reset and enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Byte stream
  input wire logic restart,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic [8*NBYTES-1:0] own_id,
  // Result
  output logic complete,
  output logic match
);
  logic [3:0] idx;
  logic differs;
  wire [7:0] own_byte = own_id[8*idx[2:0] +: 8];

  if (NBYTES != 8) begin : g_bad_size
    $error("uid_byte_compare serves 8 bytes only");
  end

  assign complete = (idx == 4'(NBYTES));
  assign match = complete & ~differs;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx <= 4'h0;
      differs <= 1'b0;
    end else if (ce) begin
      if (restart) begin
        idx <= 4'h0;
        differs <= 1'b0;
      end else if (byte_valid && !complete) begin
        idx <= idx + 4'h1;
        differs <= differs | (byte_data != own_byte);
      end
    end
  end
endmodule

// [core/rf_request_flag_filter.sv]
// Request flag decoder, answer decision and reply flag builder.
// Assumes a receiver that delivers bytes with frame start, end and
// checksum verdict, and an executor that reports errors and send end.
//
// How it works
// - Addressed: compare carried identifier with own; reply on equality.
// - Addressed with a different identifier: no reply at all.
// - Non-addressed: no identifier expected, reply regardless of identity.
// - Chosen-tag requests are answered only in the Selected state.
// - Flags are one byte; bit 3 switches bits 5-8 meaning.
// - Bit 1 picks one subcarrier (0) or two subcarriers (1).
// - Bit 2 picks low (0) or high (1) reply data rate.
// - Inventory bit 5 set means an application family byte follows.
// - Response flags byte drives all reserved positions to zero.
// - Error sets response bit 1 and adds a code byte.
// - Codes 03h unsupported option, 0Fh error without detail.
// - Codes 10h missing block, 11h relock, 12h locked block.
// - Codes 13h program fail, 14h lock fail, 15h read-protected.
// - Reserved error code values are never emitted.
// - Inventory bit 6 picks sixteen slots (0) or one slot (1).
// - Quiet tags answer all but chosen-tag and one-slot inventory requests (bit 6 set).
// - Ready tags answer any request without the chosen-tag bit.
// - A frame with a bad checksum is dropped without answer.
//
// The AHB-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
module rf_request_flag_filter (
  // Clock, reset and enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Receiver side
  input wire logic rx_sof,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_eof,
  input wire logic rx_crc_ok,
  // Executor side
  input wire logic err_req,
  input wire rf_flag_pkg::err_kind_t err_kind,
  input wire logic tx_done,
  // Decoded request
  output logic flags_valid,
  output logic [7:0] req_flags,
  output logic census,
  output logic dual_tone,
  output logic high_rate,
  output logic option_set,
  output logic expect_app_family,
  output logic single_slot,
  output logic uid_match,
  // Reply control
  output logic reply_start,
  output logic reply_active,
  output logic frame_dropped,
  output logic [7:0] resp_flags,
  output logic [7:0] err_code,
  output logic reply_params_off
);
  import rf_flag_pkg::*;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  reg_bus_if bus ();

  ahb_reg_port u_port (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .bus(bus)
  );

  logic [31:0] ctrl;
  tag_state_t tag_state;
  logic [31:0] uid_lo;
  logic [31:0] uid_hi;
  logic [7:0] drop_count;

  wire wr_ctrl = bus.wr & (bus.addr == REG_CTRL);
  wire wr_state = bus.wr & (bus.addr == REG_STATE);
  wire wr_uid_lo = bus.wr & (bus.addr == REG_UID_LO);
  wire wr_uid_hi = bus.wr & (bus.addr == REG_UID_HI);
  wire filter_on = ctrl[0];

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_FLAGS, S_COMMAND, S_SERIAL, S_BODY, S_RESPOND
  } frame_state_t;

  frame_state_t state;
  frame_state_t next_state;
  logic [7:0] flags_hold;
  logic fault;
  logic [7:0] code_hold;

  wire in_frame = (state == S_FLAGS) | (state == S_COMMAND) |
                  (state == S_SERIAL) | (state == S_BODY);
  wire start_frame = ce & filter_on & rx_sof & (state != S_RESPOND);
  wire flags_byte = (state == S_FLAGS) & rx_byte_valid;
  wire frame_end = in_frame & rx_eof;

  // Flag decode from the held byte
  wire census_bit = flags_hold[FLAG_CENSUS];
  wire chosen_bit = ~census_bit & flags_hold[FLAG_CHOSEN];
  wire addr_bit = flags_hold[FLAG_UID_MATCH];
  // The chosen-tag form carries no identifier even if the reader
  // wrongly sets the identifier bit as well
  wire serial_present = ~census_bit & addr_bit & ~chosen_bit;

  // Identifier compare
  logic id_complete;
  logic id_equal;
  wire serial_byte = (state == S_SERIAL) & rx_byte_valid;

  uid_byte_compare #(
    .NBYTES(UID_BYTES)
  ) u_cmp (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .restart(start_frame),
    .byte_valid(serial_byte),
    .byte_data(rx_byte),
    .own_id({uid_hi, uid_lo}),
    .complete(id_complete),
    .match(id_equal)
  );

  // ----------------------------------------------------------------
  // Answer decision
  // ----------------------------------------------------------------
  wire is_selected = (tag_state == TAG_SELECTED);
  wire is_quiet = (tag_state == TAG_QUIET);
  wire flags_seen = (state != S_FLAGS);
  wire census_ok = ~(is_quiet & addr_bit);
  wire chosen_ok = is_selected;
  wire addressed_ok = id_complete & id_equal;
  wire general_ok = 1'b1;
  wire mode_ok = census_bit ? census_ok :
                 chosen_bit ? chosen_ok :
                 addr_bit ? addressed_ok : general_ok;
  wire good_frame = frame_end & rx_crc_ok & flags_seen;
  wire answer = good_frame & mode_ok;

  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (start_frame) begin
          next_state = S_FLAGS;
        end
      end
      S_FLAGS: begin
        if (rx_byte_valid) begin
          next_state = S_COMMAND;
        end
      end
      S_COMMAND: begin
        if (rx_byte_valid) begin
          next_state = serial_present ? S_SERIAL : S_BODY;
        end
      end
      S_SERIAL: begin
        if (id_complete) begin
          next_state = S_BODY;
        end
      end
      S_BODY: begin
        next_state = S_BODY;
      end
      S_RESPOND: begin
        if (tx_done) begin
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
    // A new start of frame restarts the decode from its flags byte
    if (in_frame && start_frame) begin
      next_state = S_FLAGS;
    end else if (frame_end) begin
      next_state = answer ? S_RESPOND : S_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer and latched flags
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= S_IDLE;
      flags_hold <= 8'h00;
      reply_start <= 1'b0;
      frame_dropped <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      if (flags_byte) begin
        flags_hold <= rx_byte;
      end
      reply_start <= frame_end & answer;
      frame_dropped <= frame_end & ~answer;
    end
  end

  // ----------------------------------------------------------------
  // Error capture
  // ----------------------------------------------------------------
  // An error is taken only in S_RESPOND, so it never meets a new flags byte
  // in the same cycle; the flags byte clears the fault
  wire take_err = err_req & (state == S_RESPOND);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault <= 1'b0;
      code_hold <= ERR_CODE_GENERIC;
    end else if (ce) begin
      if (take_err) begin
        fault <= 1'b1;
        code_hold <= err_code_of(err_kind);
      end else if (flags_byte) begin
        fault <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= CTRL_RESET;
      tag_state <= TAG_READY;
      uid_lo <= UID_RESET;
      uid_hi <= UID_RESET;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl <= {31'h0000_0000, bus.wdata[0]};
      end
      if (wr_state) begin
        tag_state <= tag_state_t'(bus.wdata[1:0]);
      end
      if (wr_uid_lo) begin
        uid_lo <= bus.wdata;
      end
      if (wr_uid_hi) begin
        uid_hi <= bus.wdata;
      end
    end
  end

  // Dropped frame count saturates rather than wrapping
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drop_count <= 8'h00;
    end else if (ce) begin
      if (frame_end && !answer && drop_count != 8'hff) begin
        drop_count <= drop_count + 8'h01;
      end
    end
  end

  wire [31:0] status_word = {16'h0000, drop_count, 3'h0,
    id_complete, id_equal, fault, reply_active, flags_valid};
  wire [31:0] result_word = {16'h0000, code_hold, flags_hold};

  assign bus.rdata = (bus.addr == REG_CTRL) ? ctrl :
                     (bus.addr == REG_STATE) ? {30'h0, tag_state} :
                     (bus.addr == REG_UID_LO) ? uid_lo :
                     (bus.addr == REG_UID_HI) ? uid_hi :
                     (bus.addr == REG_STATUS) ? status_word :
                     (bus.addr == REG_RESULT) ? result_word :
                     32'h0000_0000;

  // ----------------------------------------------------------------
  // Decoded outputs
  // ----------------------------------------------------------------
  // The growth bit is passed through untouched; a nonzero value is
  // the reader's fault and is left to the executor to reject
  assign flags_valid = (state == S_COMMAND) | (state == S_SERIAL) |
                       (state == S_BODY) | (state == S_RESPOND);
  assign req_flags = flags_hold;
  assign census = census_bit;
  assign dual_tone = flags_hold[FLAG_DUAL_TONE];
  assign high_rate = flags_hold[FLAG_SPEED];
  assign option_set = flags_hold[FLAG_OPTION];
  assign expect_app_family = census_bit &
                             flags_hold[FLAG_APP_FAMILY];
  assign single_slot = census_bit &
                       flags_hold[FLAG_SLOT_COUNT];
  assign uid_match = id_equal;
  assign reply_active = (state == S_RESPOND);

  // Only the fault position can ever be nonzero
  assign resp_flags = {7'h00, fault};
  // Only table values reach the pin; unknown kinds fold into 0Fh
  assign err_code = code_hold;
  assign reply_params_off = fault;

endmodule

// [tb/flag_filter_props.sv]
// Concurrent checks on the request flag filter's top ports.
// Assumes one clock domain; bound to every filter instance below.
`timescale 1ns/1ns
module flag_filter_props (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus response
  input wire logic hresp,
  // Receiver and executor side
  input wire logic rx_eof,
  input wire logic rx_crc_ok,
  input wire logic err_req,
  input wire rf_flag_pkg::err_kind_t err_kind,
  input wire logic tx_done,
  // Decoded request and reply control
  input wire logic flags_valid,
  input wire logic [7:0] req_flags,
  input wire logic census,
  input wire logic dual_tone,
  input wire logic high_rate,
  input wire logic expect_app_family,
  input wire logic single_slot,
  input wire logic reply_start,
  input wire logic reply_active,
  input wire logic frame_dropped,
  input wire logic [7:0] resp_flags,
  input wire logic [7:0] err_code,
  input wire logic reply_params_off
);
  import rf_flag_pkg::*;

  // ----------------------------------------------------------------
  // Expected code for each error kind
  // ----------------------------------------------------------------
  // Kinds past the first two map onto the block codes in order
  wire [7:0] kind_code = (err_kind == ERR_OPTION) ? 8'h03 :
    (err_kind == ERR_GENERIC) ? 8'h0f : 8'h0e + 8'(err_kind);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_eof_idle;
    rx_eof && flags_valid && !reply_active;
  endsequence
  sequence s_go;
    reply_start && reply_active && !frame_dropped;
  endsequence

  property p_eof_verdict;
    s_eof_idle |=> reply_start ^ frame_dropped;
  endproperty
  property p_bad_crc;
    s_eof_idle ##0 !rx_crc_ok |=> frame_dropped;
  endproperty
  property p_start;
    reply_start |-> s_go;
  endproperty
  property p_reserved;
    resp_flags[7:1] == 7'h00;
  endproperty
  property p_params_off;
    reply_params_off == resp_flags[0];
  endproperty
  property p_err_code;
    reply_active && err_req |=> resp_flags[0] && err_code == $past(kind_code);
  endproperty
  property p_code_legal;
    err_code inside {8'h03, 8'h0f, [8'h10:8'h15]};
  endproperty
  property p_decode;
    flags_valid |-> dual_tone == req_flags[0] &&
      high_rate == req_flags[1] && census == req_flags[2];
  endproperty
  property p_inventory;
    flags_valid |-> expect_app_family == (census && req_flags[4]) &&
      single_slot == (census && req_flags[5]);
  endproperty
  property p_hold;
    reply_active ##1 reply_active |-> $stable(req_flags);
  endproperty
  property p_done;
    reply_active && tx_done |=> !reply_active;
  endproperty
  property p_okay;
    hresp == 1'b0;
  endproperty

  a_eof_verdict: assert property (p_eof_verdict)
    else $error("eof gave no single verdict");
  a_bad_crc: assert property (p_bad_crc)
    else $error("bad checksum frame not dropped");
  a_start: assert property (p_start)
    else $error("reply start without active reply");
  a_reserved: assert property (p_reserved)
    else $error("reserved response flag set");
  a_params_off: assert property (p_params_off)
    else $error("parameters not cut on fault");
  a_err_code: assert property (p_err_code)
    else $error("fault flag or code wrong");
  a_code_legal: assert property (p_code_legal)
    else $error("reserved error code");
  a_decode: assert property (p_decode)
    else $error("flag decode wrong");
  a_inventory: assert property (p_inventory)
    else $error("inventory decode wrong");
  a_hold: assert property (p_hold)
    else $error("flags moved during reply");
  a_done: assert property (p_done)
    else $error("reply not ended by send end");
  a_okay: assert property (p_okay)
    else $error("bus response not okay");
endmodule

bind rf_request_flag_filter flag_filter_props i_props (
  .hclk, .hresetn, .hresp, .rx_eof, .rx_crc_ok, .err_req, .err_kind,
  .tx_done, .flags_valid, .req_flags, .census, .dual_tone, .high_rate,
  .expect_app_family, .single_slot, .reply_start, .reply_active,
  .frame_dropped, .resp_flags, .err_code, .reply_params_off
);

// [tb/rf_reader_model.sv]
// Reader model: frames requests onto the receiver strobes.
// Assumes send is called just after a rising clock edge.
`timescale 1ns/1ns
module rf_reader_model (
  // Clock
  input wire logic hclk,
  // Receive strobes
  output logic rx_sof,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic rx_eof,
  output logic rx_crc_ok
);
  initial begin
    rx_sof = 1'b0;
    rx_byte_valid = 1'b0;
    rx_byte = 8'h00;
    rx_eof = 1'b0;
    rx_crc_ok = 1'b0;
  end

  // Gap stretches the frame; idle data is inverted so it never lingers
  task automatic send(input logic [7:0] f, input logic [63:0] id,
                      input logic ok, input int gap);
    logic [7:0] b [$];
    f[3] = 1'b0;
    if (!f[2] && f[4]) f[5] = 1'b0;
    b.push_back(f);
    b.push_back(8'h20);
    if (!f[2] && f[5])
      for (int i = 0; i < 8; i++) b.push_back(id[8*i +: 8]);
    rx_sof <= 1'b1;
    @(posedge hclk);
    rx_sof <= 1'b0;
    foreach (b[i]) begin
      rx_byte_valid <= 1'b1;
      rx_byte <= b[i];
      @(posedge hclk);
      if (gap > 0) begin
        rx_byte_valid <= 1'b0;
        rx_byte <= ~b[i];
        repeat (gap) @(posedge hclk);
      end
    end
    rx_byte_valid <= 1'b0;
    rx_eof <= 1'b1;
    rx_crc_ok <= ok;
    @(posedge hclk);
    rx_eof <= 1'b0;
    rx_crc_ok <= ~ok;
    rx_byte <= ~rx_byte;
  endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench for the request flag filter.
// Assumes the reader model and the bound checker are compiled first.
`timescale 1ns/1ns
module testbench;
  import rf_flag_pkg::*;
  logic hclk, hresetn, ce, hsel, hwrite, err_req, tx_done;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  err_kind_t err_kind;
  logic hreadyout, hresp, rx_sof, rx_byte_valid, rx_eof, rx_crc_ok;
  logic [7:0] rx_byte, req_flags, resp_flags, err_code;
  logic flags_valid, census, dual_tone, high_rate, option_set;
  logic expect_app_family, single_slot, uid_match;
  logic reply_start, reply_active, frame_dropped, reply_params_off;
  logic [7:0] codes [8];
  int bad_count, n_checks, cyc;
  // Identity value is arbitrary
  localparam logic [63:0] OWN_ID = 64'h0123_4567_89ab_cdef;

  rf_request_flag_filter i_dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .rx_sof(rx_sof),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_eof(rx_eof),
    .rx_crc_ok(rx_crc_ok), .err_req(err_req), .err_kind(err_kind),
    .tx_done(tx_done), .flags_valid(flags_valid), .req_flags(req_flags),
    .census(census), .dual_tone(dual_tone), .high_rate(high_rate),
    .option_set(option_set), .expect_app_family(expect_app_family),
    .single_slot(single_slot), .uid_match(uid_match),
    .reply_start(reply_start), .reply_active(reply_active),
    .frame_dropped(frame_dropped), .resp_flags(resp_flags),
    .err_code(err_code), .reply_params_off(reply_params_off)
  );
  rf_reader_model i_reader (
    .hclk(hclk), .rx_sof(rx_sof), .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte), .rx_eof(rx_eof), .rx_crc_ok(rx_crc_ok)
  );

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Bus and frame tasks
  // ----------------------------------------------------------------
  // Waits on hreadyout with no fixed latency; if hreadyout never rises, only the timeout ends it
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    logic ok;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'd2;
    do begin
      @(negedge hclk);
      ok = hreadyout;
      @(posedge hclk);
    end while (!ok);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(negedge hclk);
      ok = hreadyout;
      r = hrdata;
      @(posedge hclk);
    end while (!ok);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask
  task automatic frame(input logic [1:0] st, input logic [7:0] f,
                       input logic [63:0] id, input logic ok, exp);
    ahb(1'b1, REG_STATE, {30'h0, st}, rd);
    i_reader.send(f, id, ok, st);
    @(negedge hclk);
    chk(reply_start, exp);
    chk({uid_match, frame_dropped}, {exp && !f[2] && f[5], !exp});
    if (exp) begin
      chk(req_flags, f);
      chk({census, high_rate, dual_tone}, f[2:0]);
      chk({single_slot, expect_app_family}, f[2] ? f[5:4] : 2'b00);
      chk(option_set, f[6]);
      chk(resp_flags, 8'h00);
      @(posedge hclk);
      tx_done <= 1'b1;
      @(posedge hclk);
      tx_done <= 1'b0;
      @(negedge hclk);
      chk(reply_active, 1'b0);
    end
    @(posedge hclk);
    $display("frame %h done", f);
  endtask

  // ----------------------------------------------------------------
  // Clock, timeout and tests
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // Whole run needs under a thousand cycles
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      report_and_stop;
    end
  end

  initial begin
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'd0;
    hwdata = 32'h0;
    err_req = 1'b0;
    err_kind = ERR_OPTION;
    tx_done = 1'b0;
    bad_count = 0;
    n_checks = 0;
    codes = '{8'h03, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15};
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(REG_CTRL, CTRL_RESET);
    rd_chk(REG_UID_LO, UID_RESET);
    ahb(1'b1, REG_UID_LO, OWN_ID[31:0], rd);
    ahb(1'b1, REG_UID_HI, OWN_ID[63:32], rd);
    rd_chk(REG_UID_HI, OWN_ID[63:32]);
    rd_chk(8'h40, 32'h0);
    $display("registers done");
    frame(2'd2, 8'h02, OWN_ID, 1'b1, 1'b1);
    frame(2'd2, 8'h21, OWN_ID, 1'b1, 1'b1);
    frame(2'd2, 8'h21, OWN_ID ^ {8'h80, 56'h0}, 1'b1, 1'b0);
    frame(2'd2, 8'h10, OWN_ID, 1'b1, 1'b1);
    frame(2'd2, 8'h02, OWN_ID, 1'b0, 1'b0);
    frame(2'd0, 8'h36, OWN_ID, 1'b1, 1'b1);
    frame(2'd0, 8'h04, OWN_ID, 1'b1, 1'b1);
    frame(2'd1, 8'h24, OWN_ID, 1'b1, 1'b0);
    frame(2'd1, 8'h00, OWN_ID, 1'b1, 1'b1);
    frame(2'd1, 8'h21, OWN_ID, 1'b1, 1'b1);
    frame(2'd0, 8'h10, OWN_ID, 1'b1, 1'b0);
    frame(2'd0, 8'h23, OWN_ID, 1'b1, 1'b1);
    i_reader.send(8'h02, OWN_ID, 1'b1, 0);
    @(negedge hclk);
    chk(reply_active, 1'b1);
    for (int k = 0; k < 8; k++) begin
      @(posedge hclk);
      err_req <= 1'b1;
      err_kind <= err_kind_t'(k);
      @(posedge hclk);
      err_req <= 1'b0;
      @(negedge hclk);
      chk(resp_flags, 8'h01);
      chk(err_code, codes[k]);
      chk(reply_params_off, 1'b1);
    end
    @(posedge hclk);
    rd_chk(REG_RESULT, {16'h0, ERR_CODE_READ_PROT, 8'h02});
    rd_chk(REG_STATUS, 32'h0000_0407);
    i_reader.send(8'h01, OWN_ID, 1'b1, 0);
    @(negedge hclk);
    chk(req_flags, 8'h02);
    chk(reply_start, 1'b0);
    @(posedge hclk);
    tx_done <= 1'b1;
    @(posedge hclk);
    tx_done <= 1'b0;
    frame(2'd0, 8'h01, OWN_ID, 1'b1, 1'b1);
    $display("errors done");
    report_and_stop;
  end
endmodule
